// *** core/iev_ctrl.sv ***
/*
  Interrupt enable register, request gating, two-level priority arbitration and
  vector generation for the core.
  Assumes the core reaches the enable register over its SFR port, and that
  extended enables and priority bits come from neighbouring registers.
*/
module iev_ctrl (
  input  wire logic                        ref_clk,
  input  wire logic                        reset_n,
  input  wire logic                        clk_en,
  // SFR port
  input  wire logic [7:0]                  sfr_addr,
  input  wire logic                        sfr_wr,
  input  wire logic                        sfr_rd,
  input  wire logic [7:0]                  sfr_wdata,
  input  wire logic                        sfr_bit_wr,
  input  wire logic [7:0]                  sfr_bit_addr,
  input  wire logic                        sfr_bit_val,
  output logic      [7:0]                  sfr_rdata,
  // Pending flags
  input  wire logic                        ext_line_zero,
  input  wire logic                        ext_line_one,
  input  wire logic                        timer_zero_overflow,
  input  wire logic                        timer_one_overflow,
  input  wire logic                        uart_first_flag,
  input  wire logic                        timer_two_low_overflow,
  input  wire logic                        timer_two_high_overflow,
  input  wire logic                        spi_first_flag,
  input  wire logic                        rtc_alarm_flag,
  input  wire logic                        conversion_done_flag,
  input  wire logic                        core_supply_ok,
  input  wire logic                        battery_supply_ok,
  input  wire logic                        rtc_osc_fail_flag,
  input  wire logic [7:0]                  other_flags,
  // Extended enables and priorities
  input  wire logic [10:0]                 ext_irq_enable,
  input  wire logic                        supply_warn_irq_mask,
  input  wire logic [iev_pkg::IEV_NSRC-1:0] irq_priority_high,
  // Core side
  input  wire logic                        vector_ack,
  output logic                             irq_req,
  output logic      [15:0]                 irq_vector,
  output logic      [4:0]                  irq_order,
  output logic      [iev_pkg::IEV_NSRC-1:0] hw_clear
);
  import iev_pkg::*;

  typedef struct packed {
    logic [7:0]          interrupt_enable_primary;
    logic [7:0]          rdata;
    logic                req;
    logic [15:0]         vector;
    logic [4:0]          order;
    logic [IEV_NSRC-1:0] clear;
  } iev_state_t;

  iev_state_t st;
  iev_state_t next_st;

  logic [IEV_SYNC_W-1:0] pin_sync;
  logic [IEV_NSRC-1:0]   pend;
  logic [IEV_NSRC-1:0]   en;
  logic [IEV_NSRC-1:0]   req;

  iev_sync #(.W(IEV_SYNC_W)) u_sync (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .clk_en   (clk_en),
    .async_in ({battery_supply_ok, core_supply_ok, ext_line_one, ext_line_zero}),
    .sync_out (pin_sync)
  );

  wire logic [7:0] ie = st.interrupt_enable_primary;
  wire logic supply_warn = ~pin_sync[2] | ~pin_sync[3];

  // Alarm, conversion and osc-fail flags are passed through, never cleared
  assign pend = {other_flags[7], rtc_osc_fail_flag, other_flags[6], supply_warn,
                 other_flags[5:2], conversion_done_flag, other_flags[1],
                 rtc_alarm_flag, other_flags[0], spi_first_flag,
                 timer_two_low_overflow | timer_two_high_overflow,
                 uart_first_flag, timer_one_overflow, pin_sync[1],
                 timer_zero_overflow, pin_sync[0]};

  assign en = {ext_irq_enable[10:8], supply_warn_irq_mask,
               ext_irq_enable[7:0],
               ie[IEV_SPI_BIT],
               ie[IEV_TMR2_BIT],
               ie[IEV_UART_BIT],
               ie[IEV_TMR1_BIT],
               ie[IEV_EXT1_BIT],
               ie[IEV_TMR0_BIT],
               ie[IEV_EXT0_BIT]};

  // Flags are not consumed while gated, so they stay pending
  assign req = pend & en & {IEV_NSRC{ie[IEV_GATE_BIT]}};

  always_comb begin
    logic       hit_hi;
    logic       hit_lo;
    logic [4:0] win_hi;
    logic [4:0] win_lo;
    logic [4:0] win;
    hit_hi  = 1'b0;
    hit_lo  = 1'b0;
    win_hi  = IEV_ORDER_RST;
    win_lo  = IEV_ORDER_RST;
    win     = IEV_ORDER_RST;
    next_st = st;
    // Scan downward so the lowest order is left standing
    for (int i = IEV_NSRC - 1; i >= 0; i--) begin
      if (req[i] && irq_priority_high[i]) begin
        hit_hi = 1'b1;
        win_hi = 5'(i);
      end
      if (req[i] && !irq_priority_high[i]) begin
        hit_lo = 1'b1;
        win_lo = 5'(i);
      end
    end
    win = hit_hi ? win_hi : win_lo;
    next_st.req    = hit_hi | hit_lo;
    next_st.order  = win;
    next_st.vector = (hit_hi | hit_lo) ?
                     IEV_VECTOR_BASE + 16'(IEV_VECTOR_STEP * {11'h000, win}) :
                     IEV_VEC_RST;
    // Only orders 0..3 are cleared when the core takes the vector
    next_st.clear = '0;
    if (vector_ack && st.req) begin
      next_st.clear = IEV_HW_CLEAR & (19'h00001 << st.order);
    end
    if (sfr_wr && sfr_addr == IEV_ENABLE_ADDR) begin
      next_st.interrupt_enable_primary = sfr_wdata;
    end
    if (sfr_bit_wr && sfr_bit_addr[7:3] == IEV_ENABLE_ADDR[7:3]) begin
      next_st.interrupt_enable_primary[sfr_bit_addr[2:0]] = sfr_bit_val;
    end
    next_st.rdata = (sfr_rd && sfr_addr == IEV_ENABLE_ADDR) ? ie : 8'h00;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st                          <= '0;
      st.interrupt_enable_primary <= IEV_ENABLE_RST;
      st.vector                   <= IEV_VEC_RST;
      st.order                    <= IEV_ORDER_RST;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign sfr_rdata  = st.rdata;
  assign irq_req    = st.req;
  assign irq_vector = st.vector;
  assign irq_order  = st.order;
  assign hw_clear   = st.clear;
endmodule : iev_ctrl

// *** core/iev_pkg.sv ***
/*
  Constants of the interrupt enable and vectoring block: enable register
  address and fields, source order numbers, vector spacing.
  Assumes a single 40 MHz system clock shared with the core.
*/
package iev_pkg;
  localparam int          IEV_NSRC        = 19;
  localparam logic [7:0]  IEV_ENABLE_ADDR = 8'hA8;
  localparam logic [7:0]  IEV_ENABLE_RST  = 8'h00;
  localparam int          IEV_GATE_BIT    = 7;
  localparam int          IEV_SPI_BIT     = 6;
  localparam int          IEV_TMR2_BIT    = 5;
  localparam int          IEV_UART_BIT    = 4;
  localparam int          IEV_TMR1_BIT    = 3;
  localparam int          IEV_EXT1_BIT    = 2;
  localparam int          IEV_TMR0_BIT    = 1;
  localparam int          IEV_EXT0_BIT    = 0;
  localparam logic [15:0] IEV_VECTOR_BASE = 16'h0003;
  localparam logic [15:0] IEV_VECTOR_STEP = 16'h0008;
  localparam int          IEV_ORDER_CONV  = 10;
  localparam int          IEV_ORDER_WARN  = 15;
  localparam int          IEV_SYNC_W      = 4;
  // Sources whose flag hardware clears when the core vectors (orders 0..3)
  localparam logic [18:0] IEV_HW_CLEAR    = 19'h0000F;
  localparam logic [15:0] IEV_VEC_RST     = 16'h0000;
  localparam logic [4:0]  IEV_ORDER_RST   = 5'h00;
endpackage : iev_pkg

// *** core/iev_sync.sv ***
/*
  Three-stage input synchroniser with agreement filter, one per bit.
  Assumes inputs come from pins or analog monitors outside ref_clk.
*/
module iev_sync #(
  parameter int W = 4
) (
  input  wire logic         ref_clk,
  input  wire logic         reset_n,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } iev_sync_state_t;

  iev_sync_state_t st;
  iev_sync_state_t next_st;

  always_comb begin
    next_st    = st;
    next_st.s1 = async_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < W; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.q[i] = st.s3[i];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign sync_out = st.q;
endmodule : iev_sync

// *** dv/iev_ctrl_assertions.sv ***
/* Port checks for iev_ctrl: read port, vectors, flag clears.
   Bound to iev_ctrl from the testbench top file. */
module iev_ctrl_assertions (
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic        clk_en,
  input wire logic [7:0]  sfr_addr,
  input wire logic        sfr_rd,
  input wire logic [7:0]  sfr_rdata,
  input wire logic        vector_ack,
  input wire logic        irq_req,
  input wire logic [15:0] irq_vector,
  input wire logic [4:0]  irq_order,
  input wire logic [18:0] hw_clear
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  property p_rd0; clk_en && sfr_rd && sfr_addr != 8'hA8 |=> sfr_rdata == 8'h00; endproperty
  a_rd0: assert property (p_rd0) else $error("unmapped read not zero");
  property p_nord; clk_en && !sfr_rd |=> sfr_rdata == 8'h00; endproperty
  a_nord: assert property (p_nord) else $error("read data without read");
  property p_vec; irq_req |-> irq_vector == 16'h0003 + {8'h00, irq_order, 3'h0}; endproperty
  a_vec: assert property (p_vec) else $error("vector not base plus eight per order");
  property p_idle; !irq_req |-> irq_vector == 16'h0000; endproperty
  a_idle: assert property (p_idle) else $error("vector without request");
  property p_warn; irq_req && irq_order == 5'h0F |-> irq_vector == 16'h007B; endproperty
  a_warn: assert property (p_warn) else $error("supply warning vector wrong");
  property p_conv; irq_req && irq_order == 5'h0A |-> irq_vector == 16'h0053; endproperty
  a_conv: assert property (p_conv) else $error("conversion vector wrong");
  property p_keep; hw_clear[18:4] == 15'h0000; endproperty
  a_keep: assert property (p_keep) else $error("flag cleared on vectoring");
  property p_ack; clk_en && vector_ack && irq_req && irq_order == 5'h01 |=> hw_clear == 19'h00002; endproperty
  a_ack: assert property (p_ack) else $error("timer zero flag not cleared");
  c_warn: cover property (irq_req && irq_order == 5'h0F);
  c_conv: cover property (irq_req && irq_order == 5'h0A);
  c_clr: cover property (hw_clear[1]);
endmodule : iev_ctrl_assertions

// *** dv/iev_core_model.sv ***
/* Core side model: takes the vector with a one-cycle acknowledge.
   Assumes ack_en from the testbench allows it to take vectors. */
module iev_core_model (
  input  wire logic ref_clk,
  input  wire logic reset_n,
  input  wire logic ack_en,
  input  wire logic irq_req,
  output logic      vector_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) vector_ack <= 1'b0;
    else vector_ack <= ack_en && irq_req && !vector_ack;
  end
endmodule : iev_core_model

// *** dv/testbench.sv ***
/* Top testbench: enable register, masking, order and vectors of iev_ctrl.
   Assumes package, design, core model and checker are compiled first. */
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin fails++; \
  $display("unexpected %s exp %0h got %0h", n, e, a); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, reset_n, sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_val, ack_en;
  logic        core_supply_ok, supply_warn_irq_mask, vector_ack, irq_req;
  logic        battery_supply_ok, clk_en;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_bit_addr, sfr_rdata, fl;
  logic [2:0]  sf;
  logic [10:0] ext_irq_enable;
  logic [15:0] irq_vector;
  logic [4:0]  irq_order;
  logic [18:0] hw_clear, pri;
  int          fails, check_count, i, m;
  int          ord[3] = '{8, 10, 17};
  int          ebit[3] = '{1, 3, 9};
  iev_ctrl dut (.ref_clk, .reset_n, .clk_en, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
    .sfr_bit_wr, .sfr_bit_addr, .sfr_bit_val, .sfr_rdata, .ext_line_zero(fl[0]),
    .timer_zero_overflow(fl[1]), .ext_line_one(fl[2]), .timer_one_overflow(fl[3]),
    .uart_first_flag(fl[4]), .timer_two_low_overflow(fl[5]), .spi_first_flag(fl[6]),
    .timer_two_high_overflow(fl[7]), .rtc_alarm_flag(sf[0]), .conversion_done_flag(sf[1]),
    .rtc_osc_fail_flag(sf[2]), .core_supply_ok, .battery_supply_ok,
    .other_flags(8'h00), .ext_irq_enable, .supply_warn_irq_mask,
    .irq_priority_high(pri), .vector_ack, .irq_req, .irq_vector, .irq_order, .hw_clear);
  iev_core_model core (.ref_clk, .reset_n, .ack_en, .irq_req, .vector_ack);
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step
  // Byte write when b is 0, else bit write of d[0] at bit address a
  task automatic wr(input logic b, input logic [7:0] a, input logic [7:0] d);
    {sfr_wr, sfr_bit_wr, sfr_addr, sfr_bit_addr, sfr_wdata, sfr_bit_val} = {!b, b, a, a, d, d[0]};
    step(1);
    {sfr_wr, sfr_bit_wr} = 2'b00;
    step(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    {sfr_addr, sfr_rd} = {a, 1'b1};
    step(1);
    sfr_rd = 1'b0;
    `CHK("sfr_rdata", e, sfr_rdata)
    step(1);
  endtask : rd
  task automatic ck(input logic r, input logic [4:0] o);
    `CHK("irq_req", r, irq_req)
    if (r) begin
      `CHK("irq_order", o, irq_order)
      `CHK("irq_vector", 16'h0003 + {8'h00, o, 3'h0}, irq_vector)
    end
  endtask : ck
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  initial begin
    repeat (4000) @(posedge ref_clk);
    fails++;
    end_sim();
  end
  initial begin
    {reset_n, sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_val, ack_en, supply_warn_irq_mask} = '0;
    {sfr_addr, sfr_wdata, sfr_bit_addr, fl, sf, ext_irq_enable} = '0;
    {core_supply_ok, battery_supply_ok, clk_en, pri} = {3'b111, 19'h00000};
    step(10);
    reset_n = 1'b1;
    rd(8'hA8, 8'h00);
    rd(8'hA9, 8'h00);
    wr(0, 8'hA8, 8'h25);
    wr(1, 8'hAE, 8'h01);
    rd(8'hA8, 8'h65);
    // Writes elsewhere and writes while frozen must not land
    wr(0, 8'hB8, 8'hFF);
    wr(1, 8'hA7, 8'h01);
    clk_en = 1'b0;
    wr(0, 8'hA8, 8'hFF);
    clk_en = 1'b1;
    rd(8'hA8, 8'h65);
    // Bit 7 of the flag vector is the second timer two overflow
    for (i = 0; i < 8; i++) begin
      m = (i == 7) ? 5 : i;
      wr(0, 8'hA8, 8'(1 << m));
      fl[i] = 1'b1;
      step(5);
      ck(0, 5'h00);
      wr(1, 8'hAF, 8'h01);
      ck(1, 5'(m));
      wr(1, 8'(8'hA8 + m), 8'h00);
      ck(0, 5'h00);
      fl[i] = 1'b0;
    end
    wr(0, 8'hA8, 8'h8A);
    fl[3:0] = 4'hA;
    step(1);
    ck(1, 5'h01);
    ack_en = 1'b1;
    step(2);
    `CHK("hw_clear", 19'h00002, hw_clear)
    {ack_en, fl[1]} = 2'b00;
    step(2);
    ck(1, 5'h03);
    // High priority beats the lower order; equal priority falls back to order
    {fl[1], pri[3]} = 2'b11;
    step(1);
    ck(1, 5'h03);
    pri[3] = 1'b0;
    step(1);
    ck(1, 5'h01);
    {fl[1], fl[3]} = 2'b00;
    wr(0, 8'hA8, 8'h80);
    ack_en = 1'b1;
    for (i = 0; i < 3; i++) begin
      ext_irq_enable = 11'(1 << ebit[i]);
      sf[i] = 1'b1;
      step(6);
      ck(1, 5'(ord[i]));
      ext_irq_enable = 11'h000;
      step(2);
      ck(0, 5'h00);
      sf[i] = 1'b0;
    end
    {supply_warn_irq_mask, core_supply_ok} = 2'b10;
    step(6);
    ck(1, 5'h0F);
    supply_warn_irq_mask = 1'b0;
    step(2);
    ck(0, 5'h00);
    // Battery low alone warns; both supplies good drops the request
    {supply_warn_irq_mask, core_supply_ok, battery_supply_ok} = 3'b110;
    step(6);
    ck(1, 5'h0F);
    battery_supply_ok = 1'b1;
    step(6);
    ck(0, 5'h00);
    // Mid-run reset clears the enable register and the request
    reset_n = 1'b0;
    step(2);
    reset_n = 1'b1;
    rd(8'hA8, 8'h00);
    ck(0, 5'h00);
    end_sim();
  end
endmodule : testbench
bind iev_ctrl iev_ctrl_assertions chk (.ref_clk, .reset_n, .clk_en, .sfr_addr, .sfr_rd,
  .sfr_rdata, .vector_ack, .irq_req, .irq_vector, .irq_order, .hw_clear);
